/* hdl/ebc_bus_ctrl.sv */
// external bus control: wait states, direction, io strobe, owner select, clock out
`timescale 1ns/1ps
// Notes on behaviour
// R1 - ready low at check: add cycle, recheck
// R2 - ready checked only with two+ wait states
// R3 - far device raises ready when done
// R4 - direction high, low only during writes
// R5 - direction and strobe float when disabled
// R6 - only cpu accesses drive io strobe
// R7 - dma io space internal, cpu excluded
// R8 - select low: subsystem a owns bus
// R9 - select high: subsystem b owns bus
// R10 - select also picks host port target
// R11 - mode bit initialised from three pins
// R12 - clock disable bit stops clock output
// R13 - clock output floats when disabled
// R14 - clock out runs one full period per machine cycle
// R15 - host mode: ready pin drives data ready
// R16 - host mode: direction pin is input
// R17 - host mode: strobe pin is gpio3/timer
// R18 - port mode pin low host, high memory
// R19 - under two waits, fixed length access
module ebc_bus_ctrl
	import ebc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// core access request and answer
	input  wire ebc_req_s    acc_i,
	output logic             acc_done,
	output logic             dma_io_sel,
	output logic             acc_busy,
	// mode and owner pins
	input  wire logic        port_mode_pin,
	input  wire logic        host_mux_mode,
	input  wire logic        subsystem_select,
	input  wire logic        emulation_output_disable_n,
	output logic             owner_b,
	output logic             host_target_b,
	output logic             microprocessor_microcomputer_mode,
	// ready pin
	input  wire logic        ready_pin_i,
	output ebc_pin_s         ready_pin,
	// direction pin
	input  wire logic        dir_pin_i,
	output ebc_pin_s         dir_pin,
	output logic             host_rw,
	// io space strobe pin
	input  wire logic        io_strb_pin_i,
	output ebc_pin_s         io_space_strobe,
	output logic             general_io_three_a_in,
	// host port side inputs
	input  wire logic        host_data_ready,
	input  wire logic        general_io_three_a_out,
	input  wire logic        general_io_three_a_drive,
	input  wire logic        timer_output_a,
	input  wire logic        timer_output_a_sel,
	// machine clock output
	output ebc_pin_s         machine_clock_output
);
	logic [1:0]          rst_sync_reg;
	logic                rst_sync_n;
	logic [EBC_SY_W-1:0] sy1_reg;
	logic [EBC_SY_W-1:0] sy2_reg;
	logic [1:0]          init_cnt_reg;
	logic [3:0]          ws_reg;
	logic                clock_output_disable_reg;
	logic                mpmc_reg;
	logic                phase_reg;
	ebc_state_e          state_reg;
	ebc_state_e          state_next;
	logic [3:0]          cnt_reg;
	logic [3:0]          cnt_next;
	logic                wr_reg;
	logic                io_reg;
	logic [31:0]         prdata_reg;
	logic                pready_reg;
	logic                pslverr_reg;
	logic                done_reg;
	logic                dmaio_reg;
	ebc_pin_s            ready_reg;
	ebc_pin_s            dir_reg;
	ebc_pin_s            strb_reg;
	ebc_pin_s            mclk_reg;
	logic                own_b_reg;
	logic                hrw_reg;
	logic                gio_in_reg;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_reg[1];

	// every pin input passes two flops; stage one is read only by stage two
	wire [EBC_SY_W-1:0] pins_raw = {emulation_output_disable_n, subsystem_select,
		host_mux_mode, port_mode_pin, io_strb_pin_i, dir_pin_i, ready_pin_i};
	genvar gi;
	generate
		for (gi = 0; gi < EBC_SY_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					sy1_reg[gi] <= 1'b0;
					sy2_reg[gi] <= 1'b0;
				end else begin
					sy1_reg[gi] <= pins_raw[gi];
					sy2_reg[gi] <= sy1_reg[gi];
				end
			end
		end
	endgenerate

	wire ready_s  = sy2_reg[EBC_SY_READY];
	wire dir_s    = sy2_reg[EBC_SY_DIR];
	wire strb_s   = sy2_reg[EBC_SY_STRB];
	wire ext_mode = sy2_reg[EBC_SY_PMODE]; // R18
	wire hmux_s   = sy2_reg[EBC_SY_HMUX];
	wire sel_b    = sy2_reg[EBC_SY_SEL];
	wire pins_on  = sy2_reg[EBC_SY_OFF_N];

	// initial mode bit from the strap combination; external memory with
	// nonmultiplexed host pins and select low boots from off-chip memory
	function automatic logic mpmc_strap(input logic pm, input logic hm, input logic sl);
		mpmc_strap = pm & ~hm & ~sl;
	endfunction

	// apb decode
	wire apb_setup = psel & ~penable;
	wire apb_xfer  = psel & penable & pready_reg;
	wire hit_ctrl  = (paddr == EBC_CTRL_ADDR);
	wire hit_stat  = (paddr == EBC_STAT_ADDR);
	wire hit_any   = hit_ctrl | hit_stat;
	wire wr_ctrl   = apb_xfer & pwrite & hit_ctrl;

	wire [31:0] ctrl_view = {26'h000_0000, mpmc_reg, clock_output_disable_reg, ws_reg};
	wire [31:0] stat_view = {26'h000_0000, hrw_reg, mpmc_reg, ready_s,
		ext_mode, acc_busy, own_b_reg};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_view : (hit_stat ? stat_view : EBC_RD_ZERO);

	// pready raised for exactly one cycle: slave answers in the first access cycle
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= EBC_RD_ZERO;
		end else begin
			pready_reg  <= apb_setup;
			pslverr_reg <= apb_setup & ~hit_any;
			prdata_reg  <= (apb_setup & ~pwrite) ? rd_mux : EBC_RD_ZERO;
		end
	end

	// control register; mode bit caught once the strap pins have passed the
	// synchroniser, so a raw pin never feeds logic directly
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ws_reg       <= EBC_WS_RESET;
			clock_output_disable_reg   <= 1'b0;
			mpmc_reg     <= 1'b0;
			init_cnt_reg <= '0;
		end else begin
			if (init_cnt_reg != EBC_INIT_END) begin
				init_cnt_reg <= init_cnt_reg + EBC_INIT_ONE;
			end
			if (init_cnt_reg == EBC_INIT_CAP) begin
				mpmc_reg <= mpmc_strap(ext_mode, hmux_s, sel_b); // R11
			end else if (wr_ctrl) begin
				mpmc_reg <= pwdata[EBC_MPMC_BIT];
			end
			if (wr_ctrl) begin
				ws_reg     <= pwdata[EBC_WS_LSB +: EBC_WS_W];
				clock_output_disable_reg <= pwdata[EBC_CLOCK_OUTPUT_DISABLE_BIT]; // R12
			end
		end
	end

	// machine cycle is two clk_sys cycles: clock out low then high, so
	// its falling edges bound each machine cycle
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= ~phase_reg; // R14
		end
	end
	wire mc_tick = phase_reg;

	// access sequencer, steps once per machine cycle
	wire ready_checked = (ws_reg >= EBC_WS_READY_MIN); // R2
	wire ext_start = acc_i.req & ext_mode & ~(acc_i.io & acc_i.dma);
	wire dma_start = acc_i.req & acc_i.io & acc_i.dma; // R7
	wire last_cyc  = (cnt_reg == EBC_WS_ZERO);
	// R19: under two wait states the ready level is never looked at
	wire hold_ext  = ready_checked & ~ready_s; // R1 R19

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			EBC_IDLE: begin
				if (ext_start) begin
					state_next = EBC_ACC;
					cnt_next   = ws_reg;
				end else if (dma_start) begin
					state_next = EBC_DONE;
				end
			end
			EBC_ACC: begin
				if (!last_cyc) begin
					cnt_next = cnt_reg - EBC_WS_ONE;
				end else if (!hold_ext) begin // R1
					state_next = EBC_DONE;
				end
			end
			EBC_DONE: begin
				state_next = EBC_IDLE;
			end
			default: begin
				state_next = EBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= EBC_IDLE;
			cnt_reg   <= EBC_WS_ZERO;
			wr_reg    <= 1'b0;
			io_reg    <= 1'b0;
			done_reg  <= 1'b0;
			dmaio_reg <= 1'b0;
		end else begin
			done_reg  <= mc_tick & (state_reg == EBC_DONE);
			dmaio_reg <= mc_tick & (state_reg == EBC_IDLE) & dma_start; // R7
			if (mc_tick) begin
				state_reg <= state_next;
				cnt_reg   <= cnt_next;
				if (state_reg == EBC_IDLE) begin
					wr_reg <= acc_i.write;
					io_reg <= acc_i.io & ~acc_i.dma; // R6
				end
			end
		end
	end

	wire in_acc = (state_reg == EBC_ACC);

	// pin drive; off input floats the direction, strobe and clock pins
	wire gio_val = timer_output_a_sel ? timer_output_a : general_io_three_a_out; // R17
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ready_reg  <= '{o: 1'b0, oe_n: 1'b1};
			dir_reg    <= '{o: 1'b1, oe_n: 1'b1};
			strb_reg   <= '{o: 1'b1, oe_n: 1'b1};
			mclk_reg   <= '{o: 1'b1, oe_n: 1'b1};
			own_b_reg  <= 1'b0;
			hrw_reg    <= 1'b1;
			gio_in_reg <= 1'b0;
		end else begin
			own_b_reg <= sel_b; // R8 R9 R10
			if (ext_mode) begin
				ready_reg <= '{o: 1'b0, oe_n: 1'b1};
				dir_reg.o <= ~(in_acc & wr_reg); // R4
				dir_reg.oe_n <= ~pins_on; // R5
				strb_reg.o <= ~(in_acc & io_reg); // R6
				strb_reg.oe_n <= ~pins_on; // R5
			end else begin
				ready_reg <= '{o: host_data_ready, oe_n: 1'b0}; // R15
				dir_reg   <= '{o: 1'b1, oe_n: 1'b1}; // R16
				strb_reg.o <= gio_val; // R17
				strb_reg.oe_n <= ~(pins_on & general_io_three_a_drive & ~hmux_s);
			end
			hrw_reg    <= dir_s; // R16
			gio_in_reg <= strb_s; // R17
			// clock held high when stopped so no runt low pulse escapes
			mclk_reg.o    <= clock_output_disable_reg ? 1'b1 : ~phase_reg; // R12 R14
			mclk_reg.oe_n <= ~pins_on; // R13
		end
	end

	// host port has no bus access here; in host mode only dma io requests complete, others wait
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			acc_busy <= 1'b0;
		end else begin
			acc_busy <= (state_next != EBC_IDLE) | (state_reg != EBC_IDLE);
		end
	end

	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;
	assign acc_done              = done_reg;
	assign dma_io_sel            = dmaio_reg;
	assign owner_b               = own_b_reg;
	assign host_target_b         = own_b_reg;
	assign microprocessor_microcomputer_mode = mpmc_reg;
	assign ready_pin             = ready_reg;
	assign dir_pin               = dir_reg;
	assign host_rw               = hrw_reg;
	assign io_space_strobe       = strb_reg;
	assign general_io_three_a_in = gio_in_reg;
	assign machine_clock_output  = mclk_reg;
endmodule // ebc_bus_ctrl

/* shared/ebc_pkg.sv */
// shared constants and types for the external bus control block
package ebc_pkg;
	// apb register byte addresses
	localparam logic [7:0] EBC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] EBC_STAT_ADDR = 8'h04;
	// control register fields
	localparam int EBC_WS_LSB     = 0;
	localparam int EBC_WS_W       = 4;
	localparam int EBC_CLOCK_OUTPUT_DISABLE_BIT = 4;
	localparam int EBC_MPMC_BIT   = 5;
	// status register fields; stat_view holds owner at bit 0 and busy at bit 1
	localparam int EBC_ST_BUSY    = 0;
	localparam int EBC_ST_OWNER_B = 1;
	localparam int EBC_ST_EXTMODE = 2;
	localparam int EBC_ST_READY   = 3;
	localparam int EBC_ST_MPMC    = 4;
	localparam int EBC_ST_HOSTRW  = 5;
	// reset values and limits
	localparam logic [3:0] EBC_WS_RESET   = 4'h0;
	localparam logic [3:0] EBC_WS_READY_MIN = 4'h2;
	localparam logic [3:0] EBC_WS_ONE     = 4'h1;
	localparam logic [3:0] EBC_WS_ZERO    = 4'h0;
	localparam logic [31:0] EBC_RD_ZERO   = 32'h0000_0000;
	// strap capture waits until the pins have crossed the synchroniser
	localparam logic [1:0] EBC_INIT_ONE   = 2'h1;
	localparam logic [1:0] EBC_INIT_CAP   = 2'h2;
	localparam logic [1:0] EBC_INIT_END   = 2'h3;
	// synchronised pin inputs, index into the sync vector
	localparam int EBC_SY_READY = 0;
	localparam int EBC_SY_DIR   = 1;
	localparam int EBC_SY_STRB  = 2;
	localparam int EBC_SY_PMODE = 3;
	localparam int EBC_SY_HMUX  = 4;
	localparam int EBC_SY_SEL   = 5;
	localparam int EBC_SY_OFF_N = 6;
	localparam int EBC_SY_W     = 7;

	// one driven pin: level and active-low output enable
	typedef struct packed {
		logic o;
		logic oe_n;
	} ebc_pin_s;

	// access request from the owning core
	typedef struct packed {
		logic req;
		logic write;
		logic io;
		logic dma;
	} ebc_req_s;

	typedef enum logic [1:0] {EBC_IDLE, EBC_ACC, EBC_DONE} ebc_state_e;
endpackage

/* sim/ebc_bus_ctrl_assertions.sv */
// port checker for the external bus control block
`timescale 1ns/1ps
module ebc_bus_ctrl_assertions
	import ebc_pkg::*;
(
	// watched ports
	input wire logic     clk_sys,
	input wire logic     rst_n,
	input wire ebc_req_s acc_i,
	input wire logic     dma_io_sel,
	input wire logic     acc_busy,
	input wire logic     port_mode_pin,
	input wire logic     subsystem_select,
	input wire logic     emulation_output_disable_n,
	input wire logic     owner_b,
	input wire logic     host_target_b,
	input wire logic     host_data_ready,
	input wire ebc_pin_s ready_pin,
	input wire ebc_pin_s dir_pin,
	input wire ebc_pin_s io_space_strobe,
	input wire ebc_pin_s machine_clock_output
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_dir; !dir_pin.o |-> $past(acc_i.write); endproperty
	a_dir: assert property (p_dir) else $error("dir low without write");
	property p_strb; $fell(io_space_strobe.o) && acc_busy |-> $past(acc_i.io && !acc_i.dma);
	endproperty
	a_strb: assert property (p_strb) else $error("strobe without cpu io");
	property p_dma; dma_io_sel |-> io_space_strobe.o && $past(acc_i.dma && acc_i.io); endproperty
	a_dma: assert property (p_dma) else $error("dma io reached pins");
	property p_own; $stable(subsystem_select)[*8] |-> owner_b == subsystem_select; endproperty
	a_own: assert property (p_own) else $error("owner mismatch");
	property p_tgt; owner_b == host_target_b; endproperty
	a_tgt: assert property (p_tgt) else $error("host target mismatch");
	property p_off; !emulation_output_disable_n[*4] |->
		dir_pin.oe_n && io_space_strobe.oe_n && machine_clock_output.oe_n; endproperty
	a_off: assert property (p_off) else $error("pin driven while off");
	property p_clk; $fell(machine_clock_output.o) |=> machine_clock_output.o; endproperty
	a_clk: assert property (p_clk) else $error("clock low too long");
	property p_rdy; !ready_pin.oe_n |-> ready_pin.o == $past(host_data_ready); endproperty
	a_rdy: assert property (p_rdy) else $error("data ready wrong");
	property p_host; $stable(port_mode_pin)[*8] |->
		ready_pin.oe_n == port_mode_pin && (dir_pin.oe_n || port_mode_pin); endproperty
	a_host: assert property (p_host) else $error("pin roles wrong");
endmodule // ebc_bus_ctrl_assertions

/* sim/ebc_mem_model.sv */
// far-side memory device: raises ready a set number of cycles into each write or io access
`timescale 1ns/1ps
module ebc_mem_model
	import ebc_pkg::*;
(
	// clock and observed pins
	input  wire logic       clk_sys,
	input  wire ebc_pin_s   dir_pin,
	input  wire ebc_pin_s   io_space_strobe,
	input  wire logic [3:0] stall,
	// answer
	output logic            ready
);
	logic [3:0] cnt;
	// a read of plain memory leaves no pin mark, so the bench only stalls writes and io
	always_ff @(posedge clk_sys)
		if (dir_pin.o && io_space_strobe.o)
			cnt <= 4'h0;
		else if (cnt != 4'hF)
			cnt <= cnt + 4'h1;
	assign ready = cnt >= stall;
endmodule // ebc_mem_model

/* sim/test_dual_core_external_bus_control.sv */
// self-checking bench for the external bus control block
`timescale 1ns/1ps
module test_dual_core_external_bus_control
	import ebc_pkg::*;
;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err, w;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	ebc_req_s    acc;
	logic        acc_done, dma_io_sel, acc_busy, owner_b, host_target_b, mode, host_rw;
	logic        pm, hm, sel, off_n, hdr, gd, hrw, mready, tmr, tsel, gio;
	logic        tg = 1'b0;
	ebc_pin_s    ready_pin, dir_pin, strb, mclk;
	logic [3:0]  stall, ws;
	logic [1:0]  fin;
	int          n_fail, cmp_count, len, i;
	wire logic   rdy_i = ready_pin.oe_n ? mready : ready_pin.o;
	wire logic   dir_i = dir_pin.oe_n ? hrw : dir_pin.o;
	wire logic   strb_i = strb.oe_n ? tg : strb.o;
	ebc_bus_ctrl ebc_bus_ctrl_i (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .acc_i(acc), .acc_done, .dma_io_sel, .acc_busy,
		.port_mode_pin(pm), .host_mux_mode(hm), .subsystem_select(sel),
		.emulation_output_disable_n(off_n), .owner_b, .host_target_b,
		.microprocessor_microcomputer_mode(mode), .ready_pin_i(rdy_i), .ready_pin,
		.dir_pin_i(dir_i), .dir_pin, .host_rw, .io_strb_pin_i(strb_i),
		.io_space_strobe(strb), .general_io_three_a_in(gio), .host_data_ready(hdr),
		.general_io_three_a_out(hdr), .general_io_three_a_drive(gd),
		.timer_output_a(tmr), .timer_output_a_sel(tsel), .machine_clock_output(mclk));
	ebc_mem_model ebc_mem_model_i (.clk_sys, .dir_pin, .io_space_strobe(strb), .stall,
		.ready(mready));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// released lines must not hold their last level
	always @(posedge clk_sys) tg <= ~tg;
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst(input logic p, h, s);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		pm <= p;
		hm <= h;
		sel <= s;
		wt(16);
		rst_n <= 1'b1;
		wt(6);
		cmp(mode, p & ~h & ~s);
	endtask
	function automatic logic [9:0] exp_acc(input logic [3:0] n);
		return {2'b10, 8'(2 * n + 2)};
	endfunction
	task automatic acc_run(input logic wr, io, dm, input logic [3:0] st, n);
		int k;
		apb(1'b1, EBC_CTRL_ADDR, {28'h0, n});
		stall <= st;
		acc <= '{1'b1, wr, io, dm};
		len = 0;
		fin = 2'b00;
		for (k = 0; k < 400 && fin === 2'b00; k++) begin
			@(posedge clk_sys);
			len += (dir_pin.o === 1'b0 || strb.o === 1'b0);
			fin = {acc_done, dma_io_sel};
		end
		if (fin === 2'b00) begin
			n_fail++;
			test_done();
		end
		acc <= '0;
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, hdr, gd, hrw, pm, hm, sel} = 10'h004;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		acc = '0;
		off_n = 1'b1;
		{tmr, tsel} = 2'b00;
		stall = 4'h0;
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(59));
		rst(1'b1, 1'b1, 1'b0);
		rst(1'b1, 1'b0, 1'b1);
		rst(1'b1, 1'b0, 1'b0);
		apb(1'b0, EBC_CTRL_ADDR, 32'h0);
		cmp(rd, 32'h0000_0020);
		apb(1'b0, 8'h08, 32'h0);
		cmp({31'h0, err}, 32'h1);
		cmp(rd, 32'h0);
		apb(1'b0, EBC_STAT_ADDR, 32'h0);
		cmp(rd, 32'h0000_003C);
		$display("strap and register test done");
		for (i = 0; i < 2; i++) begin
			sel <= i[0];
			wt(8);
			cmp({owner_b, host_target_b}, {2{i[0]}});
			apb(1'b1, EBC_CTRL_ADDR, {27'h0, ~i[0], 4'h0});
			wt(2);
			len = 0;
			repeat (8) begin
				@(posedge clk_sys);
				len += (mclk.o === 1'b0);
			end
			cmp(len, i[0] ? 4 : 0);
		end
		$display("owner and clock test done");
		pm <= 1'b0;
		gd <= 1'b1;
		wt(4);
		repeat (4) begin
			hdr <= 1'($urandom);
			hrw <= 1'($urandom);
			tmr <= 1'($urandom);
			tsel <= 1'($urandom);
			wt(6);
			w = tsel ? tmr : hdr;
			cmp({ready_pin, dir_pin.oe_n, host_rw, strb, gio}, {hdr, 2'b01, hrw, w, 1'b0, w});
		end
		acc <= '{1'b1, 1'b1, 1'b0, 1'b0};
		wt(8);
		cmp({acc_busy, dir_pin.oe_n}, 2'b01);
		acc <= '0;
		pm <= 1'b1;
		gd <= 1'b0;
		off_n <= 1'b0;
		wt(6);
		cmp({dir_pin.oe_n, strb.oe_n, mclk.oe_n, ready_pin.oe_n}, 4'hF);
		off_n <= 1'b1;
		wt(6);
		$display("pin role test done");
		acc_run(1'b0, 1'b1, 1'b1, 4'h0, 4'h0);
		cmp({fin, len[7:0]}, 10'h100);
		acc_run(1'b1, 1'b0, 1'b0, 4'hF, 4'h1);
		cmp({fin, len[7:0]}, exp_acc(4'h1));
		repeat (12) begin
			ws = 4'($urandom % 6);
			w = 1'($urandom);
			acc_run(w, !w | 1'($urandom), 1'b0, ws < 2 ? 4'($urandom) : 4'h0, ws);
			cmp({fin, len[7:0]}, exp_acc(ws));
		end
		for (ws = 2; ws < 5; ws++) begin
			acc_run(1'b1, 1'b0, 1'b0, 4'hF, ws);
			cmp(len > 2 * ws + 2, 1);
		end
		$display("access test done");
		test_done();
	end
endmodule // test_dual_core_external_bus_control
bind ebc_bus_ctrl ebc_bus_ctrl_assertions ebc_bus_ctrl_assertions_i (.clk_sys, .rst_n, .acc_i,
	.dma_io_sel, .acc_busy, .port_mode_pin, .subsystem_select, .emulation_output_disable_n,
	.owner_b, .host_target_b, .host_data_ready, .ready_pin, .dir_pin, .io_space_strobe,
	.machine_clock_output);
